// [hw/fan_defs.svh]
`ifndef FAN_DEFS_SVH
`define FAN_DEFS_SVH

// ********************************
// timing
// ********************************
`define FAN_CLK_MHZ 200
`define FAN_TICK_US 1000
`define FAN_CYC_PER_TICK (`FAN_CLK_MHZ * `FAN_TICK_US)
`define FAN_TON_MS 500
`define FAN_TOFF_RATIO 10
`define FAN_LOW_TIMEOUT_MS 65
`define FAN_TON_TICKS (`FAN_TON_MS * 1000 / `FAN_TICK_US)
`define FAN_LOW_TIMEOUT_TICKS (`FAN_LOW_TIMEOUT_MS * 1000 / `FAN_TICK_US)

// ********************************
// hall thresholds, flux in gauss
// ********************************
`define FAN_FLUX_W 8
`define FAN_BOP_GAUSS 25
`define FAN_BRP_GAUSS (-25)

// ********************************
// reset values
// ********************************
`define FAN_POLE_RST 1'b0

`endif

// [hw/fan_drive_ctrl.sv]
`timescale 1ns/1ps
`include "fan_defs.svh"

module fan_drive_ctrl #(
  parameter int unsigned CYC_PER_TICK = `FAN_CYC_PER_TICK,
  parameter int unsigned TON_TICKS = `FAN_TON_TICKS,
  parameter int unsigned TOFF_RATIO = `FAN_TOFF_RATIO,
  parameter int unsigned LOW_TIMEOUT_TICKS = `FAN_LOW_TIMEOUT_TICKS,
  parameter int FLUX_W = `FAN_FLUX_W
) (
  input wire logic mclk_in, // 200 MHz clock
  input wire logic resetn_in, // async reset, active low
  input wire logic speed_in, // pwm speed input
  input wire logic signed [FLUX_W-1:0] flux_in, // hall flux, gauss
  output logic coil_out_a, // first coil drive
  output logic coil_out_b, // second coil drive
  output logic tacho_out // tachometer level
);

  localparam fan_pkg::div_cnt_t DIV_LAST =
    fan_pkg::div_cnt_t'(CYC_PER_TICK - 1);
  localparam fan_pkg::tick_cnt_t TON_LAST =
    fan_pkg::tick_cnt_t'(TON_TICKS - 1);
  localparam fan_pkg::tick_cnt_t TOFF_LAST =
    fan_pkg::tick_cnt_t'(TON_TICKS * TOFF_RATIO - 1);
  localparam fan_pkg::tick_cnt_t LOW_LIMIT =
    fan_pkg::tick_cnt_t'(LOW_TIMEOUT_TICKS);

  fan_pkg::fan_ctrl_s st;
  fan_pkg::fan_ctrl_s next_st;
  logic pole;
  logic tick;
  logic pole_edge;
  logic drive_en;
  logic drive_pole;

  hall_pole_detect #(
    .FLUX_W(FLUX_W)
  ) u_hall (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .flux_in(flux_in),
    .pole_out(pole)
  );

  // ********************************
  // next state
  // ********************************
  always_comb begin
    next_st = st;
    tick = (st.div_cnt == DIV_LAST);
    next_st.div_cnt = tick ? '0 : st.div_cnt + 32'h1;
    next_st.pole_prev = pole;
    pole_edge = (pole != st.pole_prev);

    if (!st.timed_out) begin
      case (st.state)
        fan_pkg::ST_RUN: begin
          if (pole_edge) begin
            next_st.stall_cnt = '0;
          end else if (tick) begin
            if (st.stall_cnt == TON_LAST) begin
              next_st.state = fan_pkg::ST_LOCK_OFF;
              next_st.stall_cnt = '0;
              next_st.lock_pole = pole;
            end else begin
              next_st.stall_cnt = st.stall_cnt + 16'h1;
            end
          end
        end
        fan_pkg::ST_LOCK_OFF: begin
          if (tick) begin
            if (st.stall_cnt == TOFF_LAST) begin
              next_st.state = fan_pkg::ST_LOCK_DRV;
              next_st.stall_cnt = '0;
            end else begin
              next_st.stall_cnt = st.stall_cnt + 16'h1;
            end
          end
        end
        fan_pkg::ST_LOCK_DRV: begin
          if (pole != st.lock_pole) begin
            next_st.state = fan_pkg::ST_RUN;
            next_st.stall_cnt = '0;
          end else if (tick) begin
            if (st.stall_cnt == TON_LAST) begin
              next_st.state = fan_pkg::ST_LOCK_OFF;
              next_st.stall_cnt = '0;
            end else begin
              next_st.stall_cnt = st.stall_cnt + 16'h1;
            end
          end
        end
        default: begin
          next_st.state = fan_pkg::ST_RUN;
          next_st.stall_cnt = '0;
        end
      endcase
    end

    // low-input watchdog overrides the sequencer
    if (speed_in) begin
      next_st.low_cnt = '0;
      next_st.timed_out = 1'b0;
    end else if (tick && !st.timed_out) begin
      if (st.low_cnt >= LOW_LIMIT) begin
        next_st.timed_out = 1'b1;
        next_st.state = fan_pkg::ST_RUN;
        next_st.stall_cnt = '0;
      end else begin
        next_st.low_cnt = st.low_cnt + 16'h1;
      end
    end

    // outputs; lock pulses stay on the side latched at stall
    drive_en = speed_in && !st.timed_out &&
      (st.state != fan_pkg::ST_LOCK_OFF);
    drive_pole = (st.state == fan_pkg::ST_LOCK_DRV) ? st.lock_pole : pole;
    next_st.coil_a = drive_en && drive_pole;
    next_st.coil_b = drive_en && !drive_pole;
    next_st.tacho = pole;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '{state: fan_pkg::ST_RUN, div_cnt: '0, stall_cnt: '0,
              low_cnt: '0, timed_out: 1'b0, lock_pole: `FAN_POLE_RST,
              pole_prev: `FAN_POLE_RST, coil_a: 1'b0, coil_b: 1'b0,
              tacho: `FAN_POLE_RST};
    end else begin
      st <= next_st;
    end
  end

  assign coil_out_a = st.coil_a;
  assign coil_out_b = st.coil_b;
  assign tacho_out = st.tacho;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  chk_coils_exclusive: assert property (
    !(coil_out_a && coil_out_b))
    else $error("both coils driven");
  chk_low_both_off: assert property (
    !speed_in |=> !coil_out_a && !coil_out_b)
    else $error("coil driven while speed input low");
  chk_high_drives_one: assert property (
    drive_en |=> coil_out_a != coil_out_b)
    else $error("no coil driven while enabled");
  chk_tacho_follows: assert property (
    $changed(coil_out_a) && !$past(st.timed_out) && $past(speed_in, 2)
      && $past(speed_in) && $past(st.state) == fan_pkg::ST_RUN
      && st.state == fan_pkg::ST_RUN |-> tacho_out == coil_out_a)
    else $error("tacho does not track first coil");
  chk_south_lock: assert property (
    st.state != fan_pkg::ST_RUN && st.lock_pole |=> !coil_out_b)
    else $error("second coil driven in south lock");
  chk_north_lock: assert property (
    st.state != fan_pkg::ST_RUN && !st.lock_pole |=> !coil_out_a)
    else $error("first coil driven in north lock");
  chk_lockoff_quiet: assert property (
    st.state == fan_pkg::ST_LOCK_OFF |=> !coil_out_a && !coil_out_b)
    else $error("coil driven in lock off-time");
  // the input may rise while timed out; the first edge still stays dark
  chk_timeout_off: assert property (
    st.timed_out |=> !coil_out_a && !coil_out_b)
    else $error("coil driven after timeout");
  chk_timeout_clear: assert property (
    $rose(st.timed_out) |-> st.state == fan_pkg::ST_RUN
      && st.stall_cnt == '0)
    else $error("lock timer not cleared on timeout");
  chk_restart_run: assert property (
    st.state == fan_pkg::ST_LOCK_DRV && pole != st.lock_pole
      && !st.timed_out && speed_in |=> st.state == fan_pkg::ST_RUN)
    else $error("no restart after rotor moved");
  chk_stall_entry: assert property (
    st.state == fan_pkg::ST_RUN && !st.timed_out && speed_in && tick
      && !pole_edge && st.stall_cnt == TON_LAST
      |=> st.state == fan_pkg::ST_LOCK_OFF)
    else $error("stall not declared after on-window");

  chk_south_drive: assert property (
    st.state == fan_pkg::ST_LOCK_DRV && st.lock_pole && speed_in
      && !st.timed_out |=> coil_out_a)
    else $error("first coil idle in south lock window");
  chk_north_drive: assert property (
    st.state == fan_pkg::ST_LOCK_DRV && !st.lock_pole && speed_in
      && !st.timed_out |=> coil_out_b)
    else $error("second coil idle in north lock window");
  chk_low_tacho: assert property (
    !speed_in |=> tacho_out == $past(pole))
    else $error("tacho does not follow pole while input low");
  chk_timeout_entry: assert property (
    !speed_in && tick && !st.timed_out && st.low_cnt == LOW_LIMIT
      |=> st.timed_out)
    else $error("low input timeout not taken");
  chk_timeout_hold: assert property (
    st.timed_out && !speed_in |=> st.timed_out)
    else $error("timeout left while input still low");
  chk_timeout_release: assert property (
    st.timed_out && speed_in |=> !st.timed_out)
    else $error("timeout kept after input went high");
  // pole motion during the off-time must not shorten it
  chk_lockoff_full: assert property (
    st.state == fan_pkg::ST_LOCK_OFF && speed_in && !st.timed_out
      && !(tick && st.stall_cnt == TOFF_LAST)
      |=> st.state == fan_pkg::ST_LOCK_OFF)
    else $error("lock off-time cut short");

  cov_stall: cover property (st.state == fan_pkg::ST_LOCK_OFF);
  cov_restart: cover property (
    st.state == fan_pkg::ST_LOCK_DRV ##1 st.state == fan_pkg::ST_RUN);
  cov_timeout: cover property ($rose(st.timed_out));
  cov_lock_drive: cover property (
    st.state == fan_pkg::ST_LOCK_DRV && (coil_out_a || coil_out_b));
  cov_wake: cover property (st.timed_out && speed_in);

endmodule

// [hw/fan_pkg.sv]
package fan_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LOCK_OFF = 2'b01,
    ST_LOCK_DRV = 2'b10
  } fan_state_e;

  typedef logic [31:0] div_cnt_t;
  typedef logic [15:0] tick_cnt_t;

  typedef struct packed {
    fan_state_e state;
    div_cnt_t div_cnt;
    tick_cnt_t stall_cnt;
    tick_cnt_t low_cnt;
    logic timed_out;
    logic lock_pole;
    logic pole_prev;
    logic coil_a;
    logic coil_b;
    logic tacho;
  } fan_ctrl_s;

  typedef struct packed {
    logic pole;
  } hall_s;

endpackage

// [hw/hall_pole_detect.sv]
`timescale 1ns/1ps
`include "fan_defs.svh"

module hall_pole_detect #(
  parameter int FLUX_W = `FAN_FLUX_W,
  parameter int BOP = `FAN_BOP_GAUSS,
  parameter int BRP = `FAN_BRP_GAUSS
) (
  input wire logic mclk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic signed [FLUX_W-1:0] flux_in, // sensed flux, gauss
  output logic pole_out // 1 = south at sensor
);

  localparam logic signed [FLUX_W-1:0] OP_TH = FLUX_W'(BOP);
  localparam logic signed [FLUX_W-1:0] RP_TH = FLUX_W'(BRP);

  fan_pkg::hall_s st;
  fan_pkg::hall_s next_st;

  // ********************************
  // hysteresis comparator
  // ********************************
  always_comb begin
    next_st = st;
    if (flux_in >= OP_TH) begin
      next_st.pole = 1'b1;
    end else if (flux_in <= RP_TH) begin
      next_st.pole = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '{pole: `FAN_POLE_RST};
    end else begin
      st <= next_st;
    end
  end

  assign pole_out = st.pole;

  chk_pole_hyst: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (flux_in > RP_TH && flux_in < OP_TH) |=> pole_out == $past(pole_out))
    else $error("pole changed inside hysteresis band");

endmodule

// [test/fan_speed_model.sv]
`timescale 1ns/1ps
// ****************
// speed controller
// ****************
module fan_speed_model #(
  parameter int unsigned PERIOD = 4000 // 50 khz at 200 mhz
) (
  input wire logic mclk_in, // clock
  input wire logic pwm_en_in, // run the pwm
  input wire logic level_in, // line level while pwm is off
  input wire logic [15:0] high_in, // high cycles per period
  output logic speed_out // speed line
);
  logic [15:0] phase = 16'h0;
  always @(posedge mclk_in) begin
    phase <= (phase == 16'(PERIOD - 1)) ? 16'h0 : phase + 16'h1;
    speed_out <= pwm_en_in ? (phase < high_in) : level_in;
  end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  localparam int unsigned CYC = 4;
  localparam int unsigned LOW_TO = 900;
  localparam int unsigned PER = 4000;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic pwm_en = 1'b0;
  logic level = 1'b0;
  logic [15:0] high_cyc = 16'h0;
  logic signed [7:0] flux = 8'sh00;
  logic speed;
  logic coil_out_a;
  logic coil_out_b;
  logic tacho_out;
  logic [2:0] q[$];
  logic [2:0] seen_out;
  int bad_count = 0;
  int comparisons = 0;
  always #2.5 mclk_in = ~mclk_in;
  fan_speed_model #(.PERIOD(PER)) i_ctl (.mclk_in(mclk_in),
    .pwm_en_in(pwm_en), .level_in(level), .high_in(high_cyc),
    .speed_out(speed));
  // long lock counts shortened; timeout kept above the longest pwm low
  fan_drive_ctrl #(.CYC_PER_TICK(CYC), .TON_TICKS(4), .TOFF_RATIO(10),
    .LOW_TIMEOUT_TICKS(LOW_TO), .FLUX_W(8)) i_dut (.mclk_in(mclk_in),
    .resetn_in(resetn_in), .speed_in(speed), .flux_in(flux),
    .coil_out_a(coil_out_a), .coil_out_b(coil_out_b),
    .tacho_out(tacho_out));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic want(input logic [2:0] e);
    q.push_back(e);
  endtask
  // outputs settle after the rising edge; compare at the falling one
  always @(negedge mclk_in) begin
    if (q.size() > 0) begin
      seen_out = {coil_out_a, coil_out_b, tacho_out};
      check({13'h0, seen_out}, {13'h0, q.pop_front()});
    end
  end
  initial begin
    step(40000);
    bad_count++;
    end_of_test();
  end
  initial begin
    logic [2:0] s_on;
    int hc;
    int cc;
    int hi;
    hc = $urandom(32'hacb6);
    step(8);
    resetn_in <= 1'b1;
    step(1);
    want(3'b000);
    level <= 1'b1;
    flux <= 8'sh19;
    step(3);
    want(3'b101);
    flux <= 8'($urandom_range(48)) - 8'sd24;
    step(3);
    want(3'b101);
    flux <= 8'she7;
    step(3);
    want(3'b010);
    level <= 1'b0;
    step(3);
    want(3'b000);
    for (int s = 1; s >= 0; s--) begin
      s_on = s[0] ? 3'b101 : 3'b010;
      level <= 1'b1;
      flux <= s[0] ? 8'sh1e : 8'she2;
      step(60);
      want({2'b00, s[0]});
      step(124);
      want(s_on);
      step(76);
      want({2'b00, s[0]});
      // toggling spans the next lock on-window, so rotation resumes there
      repeat (30) begin
        step(8);
        flux <= -flux;
      end
      step(3);
      want(s_on);
    end
    level <= 1'b0;
    step(LOW_TO * CYC + 8);
    want(3'b000);
    level <= 1'b1;
    step(3);
    want(3'b010);
    for (int k = 0; k < 2; k++) begin
      hi = PER / 100 * ((k ? 20 : 30) + $urandom_range(5));
      high_cyc <= 16'(hi);
      pwm_en <= 1'b1;
      step(1);
      hc = 0;
      cc = 0;
      // two whole periods, so the one-cycle coil lag cancels out
      for (int i = 0; i < 2 * PER; i++) begin
        step(1);
        if (i % 8 == 0) begin
          flux <= -flux;
        end
        @(negedge mclk_in);
        hc += int'(speed);
        cc += int'(coil_out_a | coil_out_b);
      end
      check(16'(cc), 16'(hc));
      check(16'(cc), 16'(2 * hi));
    end
    end_of_test();
  end
endmodule
